// ### core/rcs_reset_clock_sel.sv
/*
 * Reset and clock-select block: power-on, keyboard, shutdown and
 * fast resets stretched on the processor clock return, plus bus and
 * processor clock selection from sampled clock pins.
 * Assumes clock runs well above every sampled clock pin.
 */
`timescale 1ns/1ns
`include "rcs_consts.svh"

module rcs_reset_clock_sel (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       power_on_reset_in_n,
   input  wire logic       kbc_cpu_reset_req_n,
   input  wire logic       shutdown_detect,
   input  wire logic       double_rate_clock_in,
   input  wire logic       bus_clock_source_in,
   input  wire logic       cpu_clock_return,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            cpu_reset_out,
   output logic            system_reset_out,
   output logic            cpu_clock_out,
   output logic            expansion_bus_clock_out
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   localparam int NPIN = 6;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_ff;
   logic [NPIN-1:0] sync2_ff;
   logic [NPIN-1:0] sync3_ff;

   assign pin_raw = {cpu_clock_return, bus_clock_source_in,
                     double_rate_clock_in, shutdown_detect,
                     kbc_cpu_reset_req_n, power_on_reset_in_n};

   // two flops per pin, third stage for edge detect
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            sync1_ff[gi] <= pin_raw[gi];
            sync2_ff[gi] <= sync1_ff[gi];
            sync3_ff[gi] <= sync2_ff[gi];
         end
      end
   endgenerate

   logic por_act;
   logic kbc_act;
   logic shut_rise;
   logic dr_lvl;
   logic dr_rise;
   logic src_lvl;
   logic ret_rise;

   assign por_act   = ~sync2_ff[0];
   assign kbc_act   = ~sync2_ff[1];
   assign shut_rise = sync2_ff[2] & ~sync3_ff[2];
   assign dr_lvl    = sync2_ff[3];
   assign dr_rise   = sync2_ff[3] & ~sync3_ff[3];
   assign src_lvl   = sync2_ff[4];
   assign ret_rise  = sync2_ff[5] & ~sync3_ff[5];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] bus_clock_select_ff;
   logic [7:0] cpu_clock_select_ff;
   logic [7:0] port_reset_enable_ff;
   logic [7:0] index_fast_reset_ff;
   logic [7:0] system_control_port_ff;
   logic       wr_bus;
   logic       wr_cpu;
   logic       wr_en;
   logic       wr_idx;
   logic       wr_sys;

   assign wr_bus = reg_wr & (reg_addr == `RCS_OFS_BUS_SEL);
   assign wr_cpu = reg_wr & (reg_addr == `RCS_OFS_CPU_SEL);
   assign wr_en  = reg_wr & (reg_addr == `RCS_OFS_PORT_EN);
   assign wr_idx = reg_wr & (reg_addr == `RCS_OFS_IDX_FAST);
   assign wr_sys = reg_wr & (reg_addr == `RCS_OFS_SYS_PORT);

   // clock selects, back to defaults on any power-on reset
   always_ff @(posedge clock) begin
      if (!rst_n || por_act) begin
         bus_clock_select_ff <= `RCS_RST_REG;
         cpu_clock_select_ff <= `RCS_RST_REG;
      end else begin
         if (wr_bus) begin
            bus_clock_select_ff <= reg_wdata;
         end
         if (wr_cpu) begin
            cpu_clock_select_ff <= reg_wdata;
         end
      end
   end

   // fast reset control registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         port_reset_enable_ff   <= `RCS_RST_REG;
         index_fast_reset_ff    <= `RCS_RST_REG;
         system_control_port_ff <= `RCS_RST_REG;
      end else begin
         if (wr_en) begin
            port_reset_enable_ff <= reg_wdata;
         end
         if (wr_idx) begin
            index_fast_reset_ff <= reg_wdata;
         end
         if (wr_sys) begin
            system_control_port_ff <= reg_wdata;
         end
      end
   end

   // read data one cycle after the strobe, zero when unmapped
   logic [7:0] nxt_rdata;
   always_comb begin
      nxt_rdata = `RCS_RST_REG;
      if (reg_rd) begin
         case (reg_addr)
            `RCS_OFS_BUS_SEL:  nxt_rdata = bus_clock_select_ff;
            `RCS_OFS_CPU_SEL:  nxt_rdata = cpu_clock_select_ff;
            `RCS_OFS_PORT_EN:  nxt_rdata = port_reset_enable_ff;
            `RCS_OFS_IDX_FAST: nxt_rdata = index_fast_reset_ff;
            `RCS_OFS_SYS_PORT: nxt_rdata = {system_control_port_ff[7:1],
                                            cpu_reset_out};
            default:           nxt_rdata = `RCS_RST_REG;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= `RCS_RST_REG;
      end else begin
         reg_rdata <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // reset requests
   // ---------------------------------------------------------------
   rcs_pkg::rcs_rst_req_t req;
   logic                  port_fast;
   logic                  idx_fast;

   // rising edge against the stored bit only
   assign port_fast = wr_sys & reg_wdata[`RCS_BIT_SYS_FAST]
                    & ~system_control_port_ff[`RCS_BIT_SYS_FAST]
                    & port_reset_enable_ff[`RCS_BIT_PORT_EN];
   assign idx_fast  = wr_idx & reg_wdata[`RCS_BIT_IDX_FAST]
                    & ~index_fast_reset_ff[`RCS_BIT_IDX_FAST];

   assign req.por      = por_act;
   assign req.kbc      = kbc_act;
   assign req.fast     = port_fast | idx_fast;
   assign req.shutdown = shut_rise;

   // events seen between return edges are held until the next edge
   logic cpu_pend_ff;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cpu_pend_ff <= 1'b0;
      end else if (req.fast || req.shutdown) begin
         cpu_pend_ff <= 1'b1;
      end else if (ret_rise) begin
         cpu_pend_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // reset stretch counters on the processor clock return
   // ---------------------------------------------------------------
   logic [6:0] cpu_cnt_ff;
   logic [6:0] sys_cnt_ff;
   logic       cpu_cause;

   assign cpu_cause = req.por | req.kbc | cpu_pend_ff
                    | req.fast | req.shutdown;

   // processor reset: reload on any cause, count return edges
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cpu_cnt_ff <= `RCS_RST_CYCLES;
      end else if (ret_rise) begin
         if (cpu_cause) begin
            cpu_cnt_ff <= `RCS_RST_CYCLES;
         end else if (cpu_cnt_ff != `RCS_CNT_ZERO) begin
            cpu_cnt_ff <= cpu_cnt_ff - `RCS_CNT_ONE;
         end
      end
   end

   // system reset: power-on only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sys_cnt_ff <= `RCS_RST_CYCLES;
      end else if (ret_rise) begin
         if (req.por) begin
            sys_cnt_ff <= `RCS_RST_CYCLES;
         end else if (sys_cnt_ff != `RCS_CNT_ZERO) begin
            sys_cnt_ff <= sys_cnt_ff - `RCS_CNT_ONE;
         end
      end
   end

   // outputs change only on a return clock edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cpu_reset_out    <= 1'b1;
         system_reset_out <= 1'b1;
      end else if (ret_rise) begin
         cpu_reset_out    <= cpu_cause | (cpu_cnt_ff > `RCS_CNT_ONE);
         system_reset_out <= req.por | (sys_cnt_ff > `RCS_CNT_ONE);
      end
   end

   // ---------------------------------------------------------------
   // internal bus clock divider
   // ---------------------------------------------------------------
   rcs_pkg::rcs_clk_cfg_t cfg;
   logic [2:0]            div_ff;
   logic [2:0]            dcnt_ff;
   logic [2:0]            nxt_div;
   logic                  bclk_ff;
   logic                  bclk_q_ff;
   logic                  use_src;

   assign cfg.bus_code = bus_clock_select_ff[2:0];
   assign cfg.cpu_src  = cpu_clock_select_ff[`RCS_BIT_CPU_SEL];
   assign use_src      = (cfg.bus_code == `RCS_CODE_SRC);

   // divisor from the select code, unknown codes as divide by five
   always_comb begin
      case (cfg.bus_code)
         `RCS_CODE_DIV4: nxt_div = `RCS_DIV4;
         `RCS_CODE_DIV3: nxt_div = `RCS_DIV3;
         `RCS_CODE_DIV2: nxt_div = `RCS_DIV2;
         default:        nxt_div = `RCS_DIV5;
      endcase
   end

   // count double-rate edges; new divisor taken only at wrap
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div_ff  <= `RCS_DIV5;
         dcnt_ff <= `RCS_DIV_ZERO;
      end else if (dr_rise) begin
         if (dcnt_ff >= div_ff - `RCS_DIV_ONE) begin
            dcnt_ff <= `RCS_DIV_ZERO;
            div_ff  <= nxt_div;
         end else begin
            dcnt_ff <= dcnt_ff + `RCS_DIV_ONE;
         end
      end
   end

   // internal bus clock level: divided or straight from the source
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bclk_ff <= 1'b0;
      end else if (use_src) begin
         bclk_ff <= src_lvl;
      end else begin
         bclk_ff <= (dcnt_ff < (div_ff >> 1));
      end
   end

   // expansion clock toggles on each internal bus clock rise
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bclk_q_ff               <= 1'b0;
         expansion_bus_clock_out <= 1'b0;
      end else begin
         bclk_q_ff <= bclk_ff;
         if (bclk_ff && !bclk_q_ff) begin
            expansion_bus_clock_out <= ~expansion_bus_clock_out;
         end
      end
   end

   // ---------------------------------------------------------------
   // processor clock selector
   // ---------------------------------------------------------------
   rcs_pkg::rcs_sw_state_t sw_ff;
   logic                   cur_src_ff;
   logic                   want_src;
   logic                   cur_lvl;
   logic                   new_fall;

   assign want_src = cfg.cpu_src & use_src;
   assign cur_lvl  = cur_src_ff ? src_lvl : dr_lvl;
   // new source just fell, so a full low half follows the switch
   assign new_fall = want_src ? (~sync2_ff[4] & sync3_ff[4])
                              : (~sync2_ff[3] & sync3_ff[3]);

   // switch only while output is low and the new source just fell
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sw_ff      <= rcs_pkg::RCS_SW_RUN;
         cur_src_ff <= 1'b0;
      end else begin
         case (sw_ff)
            rcs_pkg::RCS_SW_RUN: begin
               if (want_src != cur_src_ff) begin
                  sw_ff <= rcs_pkg::RCS_SW_WAIT;
               end
            end
            rcs_pkg::RCS_SW_WAIT: begin
               if (want_src == cur_src_ff) begin
                  sw_ff <= rcs_pkg::RCS_SW_RUN;
               end else if (!cpu_clock_out && new_fall) begin
                  cur_src_ff <= want_src;
                  sw_ff      <= rcs_pkg::RCS_SW_RUN;
               end
            end
            default: sw_ff <= rcs_pkg::RCS_SW_RUN;
         endcase
      end
   end

   // pin only; low is held through a pending switch
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cpu_clock_out <= 1'b0;
      end else if (sw_ff == rcs_pkg::RCS_SW_WAIT && !cpu_clock_out) begin
         cpu_clock_out <= 1'b0;
      end else begin
         cpu_clock_out <= cur_lvl;
      end
   end

endmodule : rcs_reset_clock_sel

// ### core/rcs_consts.svh
/*
 * Constants of the reset and clock-select block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design.
 */
// Functional notes
// - Power-on reset input asserts both processor and system reset outputs.
// - Both reset outputs change only on processor clock return edges.
// - Keyboard reset request asserts processor reset only, never system reset.
// - Shutdown holds processor reset for at least 64 clocks, then releases.
// - Fast reset starts on 0-to-1 of port bit 0 or index bit 5.
// - Port fast reset works only while enable bit 6 is set.
// - Processor reset lasts at least 64 clocks for every cause.
// - System reset is clock-synchronous and lasts at least 64 clocks.
// - Expansion bus clock is internal bus clock divided by two.
// - Bus select code picks divide by 5, 4, 3, 2 or bus source.
// - Cpu select bit with code 100 picks bus source, else double-rate.
// - Selected clock only drives pin; logic runs from the return pin.
// - Processor clock source switch is glitch-free, no shortened phase, unless cancelled while pending.
// - Defaults: cpu clock double-rate, bus clock double-rate over five.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RCS_OFS_BUS_SEL   8'h07
`define RCS_OFS_CPU_SEL   8'h08
`define RCS_OFS_PORT_EN   8'h2b
`define RCS_OFS_IDX_FAST  8'h60
`define RCS_OFS_SYS_PORT  8'h92

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define RCS_BIT_CPU_SEL   0
`define RCS_BIT_PORT_EN   6
`define RCS_BIT_IDX_FAST  5
`define RCS_BIT_SYS_FAST  0
`define RCS_RST_REG       8'h00
`define RCS_RST_CODE      3'h0

// ---------------------------------------------------------------
// bus clock select codes
// ---------------------------------------------------------------
`define RCS_CODE_DIV5     3'h0
`define RCS_CODE_DIV4     3'h1
`define RCS_CODE_DIV3     3'h2
`define RCS_CODE_DIV2     3'h3
`define RCS_CODE_SRC      3'h4

// ---------------------------------------------------------------
// divisors and reset hold
// ---------------------------------------------------------------
`define RCS_DIV5          3'h5
`define RCS_DIV4          3'h4
`define RCS_DIV3          3'h3
`define RCS_DIV2          3'h2
`define RCS_RST_CYCLES    7'h40
`define RCS_CNT_ONE       7'h01
`define RCS_CNT_ZERO      7'h00
`define RCS_DIV_ONE       3'h1
`define RCS_DIV_ZERO      3'h0

`endif

// ### core/rcs_pkg.sv
/*
 * Types of the reset and clock-select block.
 * Assumes rcs_consts.svh is on the include path.
 */
`include "rcs_consts.svh"

package rcs_pkg;

   // clock configuration carried as one unit
   typedef struct packed {
      logic [2:0] bus_code;
      logic       cpu_src;
   } rcs_clk_cfg_t;

   // reset requests seen in the register clock
   typedef struct packed {
      logic por;
      logic kbc;
      logic fast;
      logic shutdown;
   } rcs_rst_req_t;

   // cpu clock switch states, one-hot
   typedef enum logic [1:0] {
      RCS_SW_RUN  = 2'b01,
      RCS_SW_WAIT = 2'b10
   } rcs_sw_state_t;

endpackage : rcs_pkg

// ### test/rcs_cpu_model.sv
/*
 * Processor-side model: a processor whose clock pin is fed from the
 * selected clock, with the same net returned to the block.
 * Assumes the block drives the clock pin as a plain level.
 */
`timescale 1ns/1ns

module rcs_cpu_model (
   input  wire logic clk_pin,
   output logic      clk_ret
);
   // processor and return pin share one net
   assign clk_ret = clk_pin;
endmodule : rcs_cpu_model

// ### test/rcs_reset_clock_sel_properties.sv
/*
 * Port assertions for the reset and clock-select block.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ns

module rcs_reset_clock_sel_properties (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       power_on_reset_in_n,
   input wire logic       kbc_cpu_reset_req_n,
   input wire logic       shutdown_detect,
   input wire logic       cpu_clock_return,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cpu_reset_out,
   input wire logic       system_reset_out,
   input wire logic       cpu_clock_out
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   logic [3:0] ret_age_ff;
   logic [3:0] phase_ff;
   logic [4:0] por_age_ff;
   logic [7:0] cpu_hold_ff;
   logic [7:0] sys_hold_ff;

   // cycles since the return clock rose
   always_ff @(posedge clock) begin
      if (!rst_n) ret_age_ff <= 4'hf;
      else if ($rose(cpu_clock_return)) ret_age_ff <= 4'h0;
      else if (ret_age_ff != 4'hf) ret_age_ff <= ret_age_ff + 4'h1;
   end

   // length of the current clock output level
   always_ff @(posedge clock) begin
      if (!rst_n) phase_ff <= 4'h7;
      else if ($changed(cpu_clock_out)) phase_ff <= 4'h1;
      else if (phase_ff != 4'hf) phase_ff <= phase_ff + 4'h1;
   end

   // cycles since the power-on pin was last low
   always_ff @(posedge clock) begin
      if (!rst_n || !power_on_reset_in_n) por_age_ff <= 5'h00;
      else if (por_age_ff != 5'h1f) por_age_ff <= por_age_ff + 5'h01;
   end

   // return edges seen while each reset output is high
   always_ff @(posedge clock) begin
      if (!rst_n || !cpu_reset_out) cpu_hold_ff <= 8'h00;
      else if ($rose(cpu_clock_return)) cpu_hold_ff <= cpu_hold_ff + 8'h01;
   end

   // same count for the system reset
   always_ff @(posedge clock) begin
      if (!rst_n || !system_reset_out) sys_hold_ff <= 8'h00;
      else if ($rose(cpu_clock_return)) sys_hold_ff <= sys_hold_ff + 8'h01;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_rst_sync: assert property (
      ($changed(cpu_reset_out) || $changed(system_reset_out))
      |-> ret_age_ff inside {[4'h1:4'h5]})
      else $error("reset output moved off the return clock");
   a_por_both: assert property (
      $fell(power_on_reset_in_n) |-> ##[1:24]
      (cpu_reset_out && system_reset_out))
      else $error("power-on reset did not raise both outputs");
   a_sys_only_por: assert property (
      $rose(system_reset_out) |-> por_age_ff < 5'h18)
      else $error("system reset rose without power-on cause");
   a_kbc_asserts: assert property (
      $fell(kbc_cpu_reset_req_n) |-> ##[1:24] cpu_reset_out)
      else $error("keyboard request did not raise cpu reset");
   a_shut_asserts: assert property (
      $rose(shutdown_detect) |-> ##[1:24] cpu_reset_out)
      else $error("shutdown did not raise cpu reset");
   a_cpu_hold: assert property (
      $fell(cpu_reset_out) |-> cpu_hold_ff >= 8'h40)
      else $error("cpu reset released too early");
   a_sys_hold: assert property (
      $fell(system_reset_out) |-> sys_hold_ff >= 8'h40)
      else $error("system reset released too early");
   a_clk_glitch: assert property (
      $changed(cpu_clock_out) |-> phase_ff >= 4'h4)
      else $error("short phase on cpu clock output");

   // main scenarios reached
   c_kbc: cover property ($fell(kbc_cpu_reset_req_n) ##[1:24] cpu_reset_out);
   c_sys: cover property ($rose(system_reset_out));
   c_slow: cover property ($changed(cpu_clock_out) && phase_ff == 4'h6);
endmodule : rcs_reset_clock_sel_properties

bind rcs_reset_clock_sel rcs_reset_clock_sel_properties u_props (
   .clock, .rst_n, .power_on_reset_in_n, .kbc_cpu_reset_req_n,
   .shutdown_detect, .cpu_clock_return, .reg_rd, .reg_rdata,
   .cpu_reset_out, .system_reset_out, .cpu_clock_out);

// ### test/rcs_reset_clock_sel_tb.sv
/*
 * Self-checking bench of the reset and clock-select block.
 * Assumes a 100 MHz clock, 80 ns double-rate and 120 ns bus sources.
 */
`timescale 1ns/1ns

module rcs_reset_clock_sel_tb;
   logic       clock, rst_n, power_on_reset_in_n, kbc_cpu_reset_req_n;
   logic       shutdown_detect, double_rate_clock_in, bus_clock_source_in;
   logic       cpu_clock_return, reg_wr, reg_rd, cpu_reset_out;
   logic       system_reset_out, cpu_clock_out, expansion_bus_clock_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int         errors, total_checks;

   // design, processor model and free-running sources
   rcs_reset_clock_sel dut (.clock, .rst_n, .power_on_reset_in_n,
      .kbc_cpu_reset_req_n, .shutdown_detect, .double_rate_clock_in,
      .bus_clock_source_in, .cpu_clock_return, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .cpu_reset_out, .system_reset_out,
      .cpu_clock_out, .expansion_bus_clock_out);
   rcs_cpu_model u_cpu (.clk_pin(cpu_clock_out), .clk_ret(cpu_clock_return));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      double_rate_clock_in = 1'b0;
      forever #40 double_rate_clock_in = ~double_rate_clock_in;
   end
   initial begin
      bus_clock_source_in = 1'b0;
      forever #60 bus_clock_source_in = ~bus_clock_source_in;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   // pin 0 power-on, 1 keyboard, 2 shutdown; held past a return period,
   // since level causes are only seen on a return clock edge
   task automatic pulse(input int k);
      @(posedge clock);
      if (k == 0) power_on_reset_in_n <= 1'b0;
      else if (k == 1) kbc_cpu_reset_req_n <= 1'b0;
      else shutdown_detect <= 1'b1;
      repeat (16) @(posedge clock);
      {power_on_reset_in_n, kbc_cpu_reset_req_n, shutdown_detect} <= 3'h6;
   endtask : pulse
   // which outputs rose, then wait for both to fall
   task automatic fire(input logic ec, input logic es);
      logic c, s;
      int   i;
      c = 1'b0;
      s = 1'b0;
      repeat (30) begin
         @(posedge clock);
         c = c | cpu_reset_out;
         s = s | system_reset_out;
      end
      chk(c, ec);
      chk(s, es);
      for (i = 0; i < 1500 && (cpu_reset_out | system_reset_out); i++)
         @(posedge clock);
      chk(cpu_reset_out | system_reset_out, 1'b0);
   endtask : fire
   // period in ns of cpu clock (w=1) or expansion clock (w=0);
   // last of eight edges, well past any pending source switch
   task automatic per(input logic w, input int e);
      time t;
      repeat (8) begin
         t = $time;
         if (w) @(posedge cpu_clock_out);
         else @(posedge expansion_bus_clock_out);
      end
      chk($time - t, e);
   endtask : per

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_defaults;
      fire(1'b1, 1'b1);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h2b, 8'h00);
      wr(8'h55, 8'hff);
      rd(8'h55, 8'h00);
      per(1'b0, 800);
      per(1'b1, 80);
   endtask : t_defaults
   task automatic t_clocks;
      int k;
      for (k = 0; k < 5; k++) begin
         wr(8'h07, k[7:0]);
         rd(8'h07, k[7:0]);
         per(1'b0, k < 4 ? 160 * (5 - k) : 240);
      end
      wr(8'h08, 8'h01);
      per(1'b1, 120);
      wr(8'h07, 8'h03);
      per(1'b1, 80);
      wr(8'h08, 8'h00);
      wr(8'h07, 8'h05);
      per(1'b0, 800);
      wr(8'h07, 8'h00);
   endtask : t_clocks
   task automatic t_kbc_shut;
      pulse(1);
      fire(1'b1, 1'b0);
      pulse(2);
      fire(1'b1, 1'b0);
   endtask : t_kbc_shut
   task automatic t_fast_index;
      wr(8'h60, 8'h20);
      fire(1'b1, 1'b0);
      wr(8'h60, 8'h20);
      fire(1'b0, 1'b0);
      wr(8'h60, 8'h00);
      wr(8'h60, 8'h20);
      fire(1'b1, 1'b0);
   endtask : t_fast_index
   task automatic t_fast_port;
      wr(8'h92, 8'h01);
      fire(1'b0, 1'b0);
      wr(8'h2b, 8'h40);
      wr(8'h92, 8'h00);
      wr(8'h92, 8'h01);
      fire(1'b1, 1'b0);
   endtask : t_fast_port
   task automatic t_power_on;
      wr(8'h07, 8'h02);
      pulse(0);
      fire(1'b1, 1'b1);
      rd(8'h07, 8'h00);
   endtask : t_power_on

   // ---------------------------------------------------------------
   // verdict, watchdog and main sequence
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // cut a hang well beyond the expected run
   initial begin
      #1000000;
      errors++;
      end_sim();
   end
   // reset, then every scenario in turn
   initial begin
      {errors, total_checks} = '0;
      {rst_n, reg_wr, reg_rd, shutdown_detect} = 4'h0;
      {power_on_reset_in_n, kbc_cpu_reset_req_n} = 2'h3;
      {reg_addr, reg_wdata} = 16'h0000;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_defaults();
      t_clocks();
      t_kbc_shut();
      t_fast_index();
      t_fast_port();
      t_power_on();
      end_sim();
   end
endmodule : rcs_reset_clock_sel_tb
